// ==== design/fws_store.sv ====
// frequency word store with serial write slave and word select
// Function
// - at power-on the four programmed words are copied into volatile storage that drives the pll.
// - serial writes change only the volatile copy, and reset restores the programmed state.
// - four words 0..3 are kept, each a six byte block.
// - a select byte holds a two bit field choosing the active word, and writing it switches.
// - the power-on select value is a programmed setting that may name any word.
// - every word can be rewritten over the serial bus.
// - the select byte sits at 40h with bits 1:0 choosing the word and bits 7:2 reserved zero.
// - the slave answers at seven bit address 69h.
`timescale 1ns/1ns
module fws_store (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [8*fws_pkg::NUM_BYTES-1:0] prog_words_i,
	input wire logic [1:0] prog_select_i,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic [8*fws_pkg::WORD_BYTES-1:0] pll_word_o,
	output logic [1:0] select_o
);
	logic scl_s;
	logic scl_p;
	logic sda_s;
	logic sda_p;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	fws_sync u_scl (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(scl_i),
		.sync_o(scl_s),
		.prev_o(scl_p)
	);
	fws_sync u_sda (
		.clock_i(clock_i),
		.reset_n_i(reset_n_i),
		.async_i(sda_i),
		.sync_o(sda_s),
		.prev_o(sda_p)
	);

	// bus events from synchronised levels only
	assign scl_rise = scl_s & ~scl_p;
	assign scl_fall = ~scl_s & scl_p;
	assign start_cond = scl_s & scl_p & sda_p & ~sda_s;
	assign stop_cond = scl_s & scl_p & ~sda_p & sda_s;

	logic [7:0] mem_q [fws_pkg::NUM_BYTES];
	logic [7:0] mem_d [fws_pkg::NUM_BYTES];
	logic [1:0] sel_q;
	logic [1:0] sel_d;
	logic loaded_q;
	logic loaded_d;
	fws_pkg::fws_state_t state_q;
	fws_pkg::fws_state_t state_d;
	logic [3:0] bit_q;
	logic [3:0] bit_d;
	logic [7:0] shift_q;
	logic [7:0] shift_d;
	logic [7:0] maddr_q;
	logic [7:0] maddr_d;
	logic ack_q;
	logic ack_d;
	logic [8*fws_pkg::WORD_BYTES-1:0] pll_q;
	logic [8*fws_pkg::WORD_BYTES-1:0] pll_d;
	logic [7:0] byte_in;
	logic [7:0] word_idx;
	logic wr_en;
	logic word_hit;
	logic sel_hit;

	assign byte_in = {shift_q[6:0], sda_s};
	assign word_idx = maddr_q - fws_pkg::WORD_BASE;
	// a data byte is complete on its eighth rising clock; start and stop need a high clock, so never coincide
	assign wr_en = loaded_q && scl_rise && bit_q == fws_pkg::BIT_COUNT_LAST && state_q == fws_pkg::FWS_DATA;
	// address decode of the byte map: four words, then the select byte
	assign word_hit = maddr_q >= fws_pkg::WORD_BASE && maddr_q <= fws_pkg::WORD_LAST;
	assign sel_hit = maddr_q == fws_pkg::SEL_ADDR;

	// serial slave next-state logic: framing, bit count, byte shift and acknowledge
	always_comb begin
		state_d = state_q;
		bit_d = bit_q;
		shift_d = shift_q;
		maddr_d = maddr_q;
		ack_d = ack_q;
		if (!loaded_q) begin
			// no frame is followed in the cycle that loads the programmed image
			state_d = fws_pkg::FWS_IDLE;
		end else if (start_cond) begin
			// a repeated start also lands here and restarts the address phase
			state_d = fws_pkg::FWS_ADDR;
			bit_d = 4'h0;
			ack_d = 1'b0;
		end else if (stop_cond) begin
			// a stop ends the frame; further bytes wait for a fresh start
			state_d = fws_pkg::FWS_IDLE;
			ack_d = 1'b0;
		end else if (scl_fall && ack_q) begin
			// release sda after the acknowledge clock
			ack_d = 1'b0;
			bit_d = 4'h0;
		end else if (scl_fall && bit_q == fws_pkg::BIT_COUNT_ACK) begin
			// pull sda low only once the clock has fallen, so no false start or stop is made
			unique case (state_q)
				fws_pkg::FWS_IDLE, fws_pkg::FWS_SKIP: ack_d = 1'b0;
				default: ack_d = 1'b1;
			endcase
		end else if (scl_rise && bit_q != fws_pkg::BIT_COUNT_ACK) begin
			// sda is taken on the rising clock, when the master must hold it stable
			shift_d = byte_in;
			bit_d = bit_q + 4'h1;
			if (bit_q == fws_pkg::BIT_COUNT_LAST) begin
				unique case (state_q)
					fws_pkg::FWS_IDLE, fws_pkg::FWS_SKIP: ;
					fws_pkg::FWS_ADDR: begin
						// only writes to our address are taken; a read gets no acknowledge
						if (byte_in[7:1] != fws_pkg::DEV_ADDR || byte_in[0]) begin
							state_d = fws_pkg::FWS_SKIP;
						end else begin
							state_d = fws_pkg::FWS_MADDR;
						end
					end
					fws_pkg::FWS_MADDR: begin
						maddr_d = byte_in;
						state_d = fws_pkg::FWS_DATA;
					end
					fws_pkg::FWS_DATA: begin
						maddr_d = maddr_q + 8'h01; // block writes walk up
					end
				endcase
			end
		end
	end

	// slave registers
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			state_q <= fws_pkg::FWS_IDLE;
			bit_q <= 4'h0;
			shift_q <= 8'h00;
			maddr_q <= 8'h00;
			ack_q <= 1'b0;
		end else begin
			state_q <= state_d;
			bit_q <= bit_d;
			shift_q <= shift_d;
			maddr_q <= maddr_d;
			ack_q <= ack_d;
		end
	end

	// store and select next values
	always_comb begin
		mem_d = mem_q;
		sel_d = sel_q;
		loaded_d = 1'b1;
		if (!loaded_q) begin
			// first cycle after reset: copy programmed image
			for (int i = 0; i < fws_pkg::NUM_BYTES; i++) begin
				mem_d[i] = prog_words_i[8*i +: 8];
			end
			sel_d = prog_select_i;
		end else if (wr_en) begin
			// bytes outside the map are acknowledged but dropped, so a stray write cannot corrupt the store
			if (word_hit) begin
				mem_d[word_idx[4:0]] = byte_in;
			end else if (sel_hit) begin
				sel_d = byte_in[1:0] & fws_pkg::SEL_WIDTH_MASK; // reserved bits not kept
			end
		end
	end

	// volatile store: reset clears everything to zero; the programmed image returns in the first cycle after reset
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			for (int i = 0; i < fws_pkg::NUM_BYTES; i++) begin
				mem_q[i] <= 8'h00;
			end
			sel_q <= 2'h0;
			loaded_q <= 1'b0;
		end else begin
			mem_q <= mem_d;
			sel_q <= sel_d;
			loaded_q <= loaded_d;
		end
	end

	// pll word follows the select with no extra command
	always_comb begin
		pll_d = pll_q;
		if (loaded_q) begin
			for (int b = 0; b < fws_pkg::WORD_BYTES; b++) begin
				pll_d[8*b +: 8] = mem_q[sel_q * fws_pkg::WORD_BYTES + b];
			end
		end
	end

	// pll word register: a rewrite of the selected word shows at once, hence the host keeps to idle words
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			pll_q <= '0;
		end else begin
			pll_q <= pll_d;
		end
	end

	assign sda_o = 1'b0; // open drain: only ever pulls low
	assign sda_oe_o = ack_q;
	assign pll_word_o = pll_q;
	assign select_o = sel_q;
endmodule : fws_store

// ==== design/fws_pkg.sv ====
// package: constants for the frequency word select store
package fws_pkg;
	localparam int unsigned NUM_WORDS = 4;
	localparam int unsigned WORD_BYTES = 6;
	localparam int unsigned NUM_BYTES = NUM_WORDS * WORD_BYTES;
	localparam logic [6:0] DEV_ADDR = 7'h69;
	localparam logic [7:0] WORD_BASE = 8'h10;
	localparam logic [7:0] WORD_LAST = 8'h27;
	localparam logic [7:0] SEL_ADDR = 8'h40;
	localparam logic [7:0] SEL_RESERVED = 8'h00;
	localparam logic [3:0] BIT_COUNT_LAST = 4'h7;
	localparam logic [3:0] BIT_COUNT_ACK = 4'h8;
	localparam logic [1:0] SEL_WIDTH_MASK = 2'h3;
	typedef enum logic [4:0] {
		FWS_IDLE = 5'b00001,
		FWS_ADDR = 5'b00010,
		FWS_MADDR = 5'b00100,
		FWS_DATA = 5'b01000,
		FWS_SKIP = 5'b10000
	} fws_state_t;
endpackage : fws_pkg

// ==== design/fws_sync.sv ====
// two flip-flop synchroniser with a registered copy for edge detection
`timescale 1ns/1ns
module fws_sync (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic async_i,
	output logic sync_o,
	output logic prev_o
);
	logic meta_q;
	logic meta_d;
	logic sync_q;
	logic sync_d;
	logic prev_q;
	logic prev_d;

	// first stage is read only by the second
	always_comb begin
		meta_d = async_i;
		sync_d = meta_q;
		prev_d = sync_q;
	end

	// idle bus level is high, so reset to one
	always_ff @(posedge clock_i) begin
		if (!reset_n_i) begin
			meta_q <= 1'b1;
			sync_q <= 1'b1;
			prev_q <= 1'b1;
		end else begin
			meta_q <= meta_d;
			sync_q <= sync_d;
			prev_q <= prev_d;
		end
	end

	assign sync_o = sync_q;
	assign prev_o = prev_q;
endmodule : fws_sync

// ==== test/fws_assertions.sv ====
// checker on the frequency word store ports
`timescale 1ns/1ns
module fws_assertions (
	input wire logic clock_i,
	input wire logic reset_n_i,
	input wire logic [8*fws_pkg::NUM_BYTES-1:0] prog_words_i,
	input wire logic [1:0] prog_select_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic sda_o,
	input wire logic sda_oe_o,
	input wire logic [8*fws_pkg::WORD_BYTES-1:0] pll_word_o,
	input wire logic [1:0] select_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!reset_n_i);
	// an ack stands for at least eight clock cycles once raised
	sequence ack_held;
		sda_oe_o [*8];
	endsequence
	rst_clear_a: assert property (disable iff (1'b0)
		!reset_n_i |=> !sda_oe_o && select_o == 2'h0) else $error("reset clear");
	boot_sel_a: assert property ($rose(reset_n_i) |=> select_o == prog_select_i) else $error("boot sel");
	boot_word_a: assert property ($rose(reset_n_i) |=> ##1
		pll_word_o == prog_words_i[48*prog_select_i +: 48]) else $error("boot word");
	drain_only_a: assert property (sda_o == 1'b0) else $error("sda driven high");
	ack_low_a: assert property ($rose(sda_oe_o) |-> !scl_i) else $error("ack edge");
	ack_hold_a: assert property ($rose(sda_oe_o) |=> ack_held) else $error("ack short");
	// state may only move while the serial clock is high, never on its own
	sel_move_a: assert property ($changed(select_o) |-> scl_i) else $error("select move");
	word_move_a: assert property ($changed(pll_word_o) |-> scl_i) else $error("word move");
endmodule: fws_assertions
bind fws_store fws_assertions chk (.clock_i(clock_i), .reset_n_i(reset_n_i), .prog_words_i(prog_words_i),
	.prog_select_i(prog_select_i), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
	.pll_word_o(pll_word_o), .select_o(select_o));

// ==== test/fws_host.sv ====
// serial bus host model for the frequency word store
`timescale 1ns/1ns
module fws_host (
	input wire logic clock_i,
	input wire logic sda_i,
	output logic scl_o,
	output logic sda_o
);
	initial begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	// one third of a bit; long phases give the 2-flop input sync room
	task automatic q(input logic c, input logic d);
		repeat (12) @(posedge clock_i);
		#1 scl_o = c;
		sda_o = d;
	endtask: q
	// nine clocks, msb first; data moves only while the clock is low
	task automatic send(input logic [8:0] v, output logic ack);
		for (int i = 8; i >= 0; i--) begin
			q(1'b0, v[i]);
			q(1'b1, v[i]);
			ack = !sda_i;
			q(1'b0, v[i]);
		end
	endtask: send
endmodule: fws_host

// ==== test/fws_store_tb.sv ====
// testbench for the frequency word store
`timescale 1ns/1ns
module fws_store_tb;
	logic clock_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic [191:0] img;
	logic [1:0] psel = 2'h3;
	logic scl, sda_h, sda_oe_o, sda_o, ack;
	logic [47:0] pll_word_o;
	logic [1:0] select_o;
	int fail_count = 0;
	int comparisons = 0;
	// pulled-up line, low while either side pulls
	wire sda_line = sda_h & ~sda_oe_o;
	always #4 clock_i = ~clock_i;
	initial for (int i = 0; i < 24; i++) img[8*i +: 8] = 8'h30 + 8'(i);
	fws_host h (.clock_i(clock_i), .sda_i(sda_line), .scl_o(scl), .sda_o(sda_h));
	fws_store uut (.clock_i(clock_i), .reset_n_i(reset_n_i), .prog_words_i(img), .prog_select_i(psel), .scl_i(scl),
		.sda_i(sda_line), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .pll_word_o(pll_word_o), .select_o(select_o));
	task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD %s exp %h seen %h", nm, e, s);
		end
	endtask: chk
	// one write frame; address ack lands in ack
	task automatic wr(input logic [6:0] da, input logic [7:0] ma, input logic [47:0] d, input int n);
		logic a;
		h.q(1'b1, 1'b0);
		h.q(1'b0, 1'b0);
		h.send({da, 2'b01}, ack);
		h.send({ma, 1'b1}, a);
		for (int k = 0; k < n; k++)
			h.send({d[8*k +: 8], 1'b1}, a);
		h.q(1'b0, 1'b0);
		h.q(1'b1, 1'b0);
		h.q(1'b1, 1'b1);
	endtask: wr
	task automatic t_boot(input logic [1:0] ps);
		@(posedge clock_i);
		#1 reset_n_i = 1'b0;
		psel = ps;
		repeat (16) @(posedge clock_i);
		#1 reset_n_i = 1'b1;
		repeat (4) @(posedge clock_i);
		chk("select", 48'(select_o), 48'(ps));
		chk("word", pll_word_o, img[48*ps +: 48]);
	endtask: t_boot
	// idle word rewritten as one block first, then selected
	task automatic t_swap();
		wr(fws_pkg::DEV_ADDR, 8'h16, 48'h665544332211, 6);
		chk("ack", 48'(ack), 48'h1);
		chk("word", pll_word_o, img[144 +: 48]);
		wr(fws_pkg::DEV_ADDR, fws_pkg::SEL_ADDR, 48'h01, 1);
		// relock allowance before the new clock is trusted
		repeat (64) @(posedge clock_i);
		chk("select", 48'(select_o), 48'h1);
		chk("word", pll_word_o, 48'h665544332211);
	endtask: t_swap
	// select written with reserved bits zero, then a foreign address refused
	task automatic t_odd();
		wr(fws_pkg::DEV_ADDR, fws_pkg::SEL_ADDR, 48'h02, 1);
		chk("select", 48'(select_o), 48'h2);
		chk("word", pll_word_o, img[96 +: 48]);
		wr(7'h6a, fws_pkg::SEL_ADDR, 48'h00, 1);
		chk("ack", 48'(ack), 48'h0);
		chk("select", 48'(select_o), 48'h2);
	endtask: t_odd
	// edits vanish at the next power-on
	task automatic t_vol();
		t_boot(2'h0);
		wr(fws_pkg::DEV_ADDR, fws_pkg::SEL_ADDR, 48'h01, 1);
		chk("word", pll_word_o, img[48 +: 48]);
	endtask: t_vol
	task automatic final_report();
		if (fail_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask: final_report
	initial begin
		t_boot(2'h3);
		t_swap();
		t_odd();
		t_vol();
		final_report();
	end
	// run needs about 7k cycles
	initial begin
		#500000;
		fail_count++;
		final_report();
	end
endmodule: fws_store_tb
